// ==== logic/lrg_pkg.sv ====
package lrg_pkg;

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int TB_HZ = 10_000_000;
	localparam int TB_WIN_US = 100;
	localparam int TB_WIN_CYC = TB_WIN_US * (CLK_HZ / 1_000_000);
	localparam int TB_TOL_PCT = 1;

	// ----------------------------------------------------------------
	// register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] LRG_CTRL = 8'h00;
	localparam logic [7:0] LRG_CMD = 8'h04;
	localparam logic [7:0] LRG_PHASE = 8'h08;
	localparam logic [7:0] LRG_FREQ_LO = 8'h0c;
	localparam logic [7:0] LRG_FREQ_HI = 8'h10;
	localparam logic [7:0] LRG_HARM = 8'h14;
	localparam logic [7:0] LRG_AMPL = 8'h18;
	localparam logic [7:0] LRG_DCLVL = 8'h1c;
	localparam logic [7:0] LRG_STATUS = 8'h20;
	localparam logic [7:0] LRG_EXT_INC = 8'h24;
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_TRIG_LSB = 2;
	localparam int CTRL_DC_COMMON = 4;
	localparam int CTRL_HARM_EXT = 5;
	localparam int CMD_PH_ZERO = 0;
	localparam int CMD_PH_PLUS = 1;
	localparam int CMD_PH_MINUS = 2;
	localparam int CMD_PH_AUTO = 3;
	localparam int CMD_HARM_UP = 4;
	localparam int CMD_HARM_DOWN = 5;
	localparam int CMD_HARM_RESET = 6;
	localparam int CMD_AMPL_ZERO = 7;
	localparam int CMD_DC_ZERO = 8;
	localparam int HARM_EXT_LSB = 8;

	// phase in millidegrees, frequency in 0.1 mHz, amplitude in nV, dc in 0.1 mV
	localparam logic signed [20:0] PH_MAX = 21'sd180000;
	localparam logic signed [20:0] PH_QUARTER = 21'sd90000;
	localparam logic [17:0] PH_SCALE = 18'd47722;  // 2^34 / 360000, word = mdeg*scale >> 18
	localparam logic [35:0] FREQ_MIN = 36'd10;
	localparam logic [35:0] FREQ_MAX = 36'd5_000_000_000;
	localparam logic [35:0] FREQ_RST = 36'd10_000_000;
	localparam logic [63:0] NCO_K = 64'((2.0 ** 64) / (real'(CLK_HZ) * 1.0e4));
	localparam logic [6:0] HARM_MIN = 7'd1;
	localparam logic [6:0] HARM_MAX = 7'd99;
	localparam logic [30:0] AMPL_MAX = 31'd2_000_000_000;
	localparam logic [30:0] AMPL_RST = 31'd0;
	localparam logic signed [16:0] DC_MAX = 17'sd50000;
	localparam logic signed [16:0] DC_RST = 17'sd0;

	// ----------------------------------------------------------------
	// external reference tracking
	// ----------------------------------------------------------------
	localparam int REF_MIN_PERIOD_NS = 2000;
	localparam logic [39:0] REF_MIN_CYC = 40'((REF_MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS);
	localparam longint REF_MAX_PERIOD_S = 1000;
	localparam logic [48:0] DIV_NUM = 49'h1_0000_0000_0000;
	localparam logic [5:0] DIV_STEPS = 6'd49;
	localparam int CHOP_TOL_SHIFT = 6;

	typedef enum logic [1:0] {
		LRG_SRC_INT = 2'b00,
		LRG_SRC_EXT = 2'b01,
		LRG_SRC_DUAL = 2'b10,
		LRG_SRC_CHOP = 2'b11
	} lrg_src_t;

	typedef enum logic [1:0] {
		LRG_TRIG_POS = 2'b00,
		LRG_TRIG_NEG = 2'b01,
		LRG_TRIG_SINE = 2'b10,
		LRG_TRIG_OFF = 2'b11
	} lrg_trig_t;

	typedef struct packed {
		logic [15:0] phase_i;
		logic [15:0] phase_q;
	} lrg_det_t;

	typedef struct packed {
		logic [15:0] phase;
		logic [30:0] ampl;
		logic signed [16:0] dc_pos;
		logic signed [16:0] dc_neg;
	} lrg_sine_t;

endpackage

// ==== logic/lrg_ref_gen.sv ====
// Behaviour
// - lock to chosen TTL edge polarity
// - sine trigger locks to rising zero crossings
// - external or dual: unlock when not locked
// - chop: unlock means chopper not locked
// - flag lock to external 10 MHz timebase
// - phase -180..+180 at 0.001 deg; zero command
// - phase shifts only detector sines
// - auto phase subtracts measured angle
// - quarter-turn adds or subtracts 90.000 deg
// - frequency writes ignored in external mode
// - frequency 1.0 mHz..500 kHz, 0.1 mHz step
// - frequency ceiling is 500 kHz / harmonic
// - harmonic reset command returns to fundamental
// - harmonic steps kept within 1..99
// - internal/chop: internal multiplier times internal frequency
// - external: external multiplier times tracked frequency
// - dual: difference of both harmonic products
// - sine output stays at fundamental
// - amplitude 1 nV..2.00 Vrms, zero command
// - dc level -5.00..+5.00 V, 0.1 mV step
// - dc mode difference or common sign
// - external or chop: sine locked to reference
//
// Design decisions made here: the register offsets and register access over APB.
module lrg_ref_gen
	import lrg_pkg::*;
#(
	parameter logic [39:0] REF_TIMEOUT_CYC = 40'(REF_MAX_PERIOD_S * CLK_HZ),
	parameter int TB_WIN = TB_WIN_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic ref_ttl,
	input wire logic ref_cmp,
	input wire logic tb_ext,
	input wire logic signed [18:0] theta_meas,
	output lrg_det_t det_ref_q,
	output lrg_sine_t sine_q,
	output logic unlock_q,
	output logic external_timebase_locked_flag_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic signed [18:0] ph_wrap(input logic signed [20:0] x);
		logic signed [20:0] y;
		y = x;
		if (x > PH_MAX) begin
			y = x - 21'(2 * PH_MAX);
		end else if (x < -PH_MAX) begin
			y = x + 21'(2 * PH_MAX);
		end
		return 19'(y);
	endfunction
	function automatic logic [15:0] ph_word(input logic signed [18:0] m);
		logic signed [37:0] p;
		p = 38'(m) * $signed({20'd0, PH_SCALE});
		return p[33:18];
	endfunction
	function automatic logic [15:0] harm_mul(input logic [6:0] n, input logic [15:0] ph);
		logic [22:0] p;
		p = 23'(n) * 23'(ph);
		return p[15:0];
	endfunction
	function automatic logic [47:0] nco_inc(input logic [35:0] f);
		logic [63:0] p;
		p = 64'(f) * NCO_K;
		return p[63:16];
	endfunction

	// ----------------------------------------------------------------
	// apb slave, one wait state
	// ----------------------------------------------------------------
	logic [5:0] ctrl_q;
	logic signed [18:0] phase_q;
	logic [31:0] freq_lo_q;
	logic [35:0] freq_q;
	logic [6:0] n_int_q, n_ext_q;
	logic [30:0] ampl_q;
	logic signed [16:0] dc_q;
	logic ext_lock_q, chop_lock_q;
	logic [47:0] ext_inc_q, int_inc_q;
	wire acc_w = psel & penable & pready_q;
	wire wr_w = acc_w & pwrite;
	wire ans_w = psel & penable & ~pready_q;
	wire hit_w = (paddr[1:0] == 2'b00) && (paddr <= LRG_EXT_INC);
	wire [8:0] cmd_w = (wr_w && paddr == LRG_CMD) ? pwdata[8:0] : 9'd0;
	wire lrg_src_t src_w = lrg_src_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
	wire lrg_trig_t trig_w = lrg_trig_t'(ctrl_q[CTRL_TRIG_LSB +: 2]);
	wire [31:0] rdata_w =
		(paddr == LRG_CTRL) ? {26'd0, ctrl_q} :
		(paddr == LRG_PHASE) ? 32'(phase_q) :
		(paddr == LRG_FREQ_LO) ? freq_q[31:0] :
		(paddr == LRG_FREQ_HI) ? {28'd0, freq_q[35:32]} :
		(paddr == LRG_HARM) ? {17'd0, n_ext_q, 1'b0, n_int_q} :
		(paddr == LRG_AMPL) ? {1'b0, ampl_q} :
		(paddr == LRG_DCLVL) ? 32'(dc_q) :
		(paddr == LRG_STATUS) ? {28'd0, chop_lock_q, ext_lock_q,
			external_timebase_locked_flag_q, unlock_q} :
		(paddr == LRG_EXT_INC) ? ext_inc_q[47:16] : 32'd0;

	always_ff @(posedge clk) begin
		pready_q <= ~rst & ans_w;
		pslverr_q <= ~rst & ans_w & ~hit_w;
		prdata_q <= (rst | ~ans_w | pwrite) ? 32'd0 : rdata_w;
	end

	// ----------------------------------------------------------------
	// reference phase setting
	// ----------------------------------------------------------------
	wire signed [20:0] ph_ext_w = 21'(phase_q);
	wire signed [31:0] wr_ph_w = $signed(pwdata);
	wire signed [18:0] ph_wr_w = (wr_ph_w > 32'(PH_MAX)) ? 19'(PH_MAX) :
		(wr_ph_w < -32'(PH_MAX)) ? 19'(-PH_MAX) : 19'(wr_ph_w);
	wire signed [18:0] phase_d =
		cmd_w[CMD_PH_ZERO] ? 19'sd0 :
		cmd_w[CMD_PH_AUTO] ? ph_wrap(ph_ext_w - 21'(theta_meas)) :
		cmd_w[CMD_PH_PLUS] ? ph_wrap(ph_ext_w + PH_QUARTER) :
		cmd_w[CMD_PH_MINUS] ? ph_wrap(ph_ext_w - PH_QUARTER) :
		(wr_w && paddr == LRG_PHASE) ? ph_wr_w : phase_q;

	// ----------------------------------------------------------------
	// frequency and harmonic numbers
	// ----------------------------------------------------------------
	wire [35:0] freq_new_w = {pwdata[3:0], freq_lo_q};
	wire freq_ok_w = (src_w != LRG_SRC_EXT) && (freq_new_w >= FREQ_MIN)
		&& (43'(freq_new_w) * 43'(n_int_q) <= 43'(FREQ_MAX));
	wire harm_ext_w = (src_w == LRG_SRC_EXT) || (src_w == LRG_SRC_DUAL && ctrl_q[CTRL_HARM_EXT]);
	wire [6:0] n_sel_w = harm_ext_w ? n_ext_q : n_int_q;
	wire int_fit_w = 43'(freq_q) * 43'(n_int_q + 7'd1) <= 43'(FREQ_MAX);
	wire up_w = cmd_w[CMD_HARM_UP] && n_sel_w != HARM_MAX && (harm_ext_w || int_fit_w);
	wire dn_w = cmd_w[CMD_HARM_DOWN] && n_sel_w != HARM_MIN;
	wire [6:0] n_step_w = up_w ? n_sel_w + 7'd1 : dn_w ? n_sel_w - 7'd1 : n_sel_w;
	wire [6:0] n_int_d = cmd_w[CMD_HARM_RESET] ? HARM_MIN :
		harm_ext_w ? n_int_q : n_step_w;
	wire [6:0] n_ext_d = cmd_w[CMD_HARM_RESET] ? HARM_MIN :
		harm_ext_w ? n_step_w : n_ext_q;

	// ----------------------------------------------------------------
	// sine output settings
	// ----------------------------------------------------------------
	wire signed [31:0] wr_dc_w = $signed(pwdata);
	wire [30:0] ampl_d = cmd_w[CMD_AMPL_ZERO] ? 31'd0 :
		!(wr_w && paddr == LRG_AMPL) ? ampl_q :
		(pwdata > 32'(AMPL_MAX)) ? AMPL_MAX : pwdata[30:0];
	wire signed [16:0] dc_d = cmd_w[CMD_DC_ZERO] ? 17'sd0 :
		!(wr_w && paddr == LRG_DCLVL) ? dc_q :
		(wr_dc_w > 32'(DC_MAX)) ? DC_MAX :
		(wr_dc_w < -32'(DC_MAX)) ? -DC_MAX : 17'(wr_dc_w);

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= 6'd0;
			phase_q <= 19'sd0;
			freq_lo_q <= 32'd0;
			freq_q <= FREQ_RST;
			n_int_q <= HARM_MIN;
			n_ext_q <= HARM_MIN;
			ampl_q <= AMPL_RST;
			dc_q <= DC_RST;
		end else begin
			if (wr_w && paddr == LRG_CTRL) begin
				ctrl_q <= pwdata[5:0];
			end
			if (wr_w && paddr == LRG_FREQ_LO) begin
				freq_lo_q <= pwdata;
			end
			if (wr_w && paddr == LRG_FREQ_HI && freq_ok_w) begin
				freq_q <= freq_new_w;
			end
			phase_q <= phase_d;
			n_int_q <= n_int_d;
			n_ext_q <= n_ext_d;
			ampl_q <= ampl_d;
			dc_q <= dc_d;
		end
	end

	// ----------------------------------------------------------------
	// external reference capture
	// ----------------------------------------------------------------
	// stage 0 is read only by stage 1; edges are taken from stages 1 and 2
	logic [2:0] ttl_s_q, cmp_s_q, tb_s_q;
	logic [39:0] per_cnt_q, div_per_q;
	logic ext_seen_q;
	logic [5:0] div_cnt_q;
	logic [40:0] div_rem_q;
	logic [48:0] div_num_q, div_quo_q;
	logic [47:0] ext_acc_q, int_acc_q;
	wire ttl_rise_w = ttl_s_q[1] & ~ttl_s_q[2];
	wire ttl_fall_w = ~ttl_s_q[1] & ttl_s_q[2];
	wire cmp_rise_w = cmp_s_q[1] & ~cmp_s_q[2];
	wire ext_edge_w = (trig_w == LRG_TRIG_POS) ? ttl_rise_w :
		(trig_w == LRG_TRIG_NEG) ? ttl_fall_w :
		(trig_w == LRG_TRIG_SINE) ? cmp_rise_w : 1'b0;
	wire per_top_w = per_cnt_q == REF_TIMEOUT_CYC;
	wire per_good_w = ext_seen_q && per_cnt_q >= REF_MIN_CYC && !per_top_w;
	wire ext_lock_d = ext_edge_w ? per_good_w : (per_top_w ? 1'b0 : ext_lock_q);
	// period to increment: 2^48 / period, one quotient bit per cycle
	wire [40:0] dv_trial_w = {div_rem_q[39:0], div_num_q[48]};
	wire dv_ge_w = dv_trial_w >= {1'b0, div_per_q};
	wire [48:0] dv_quo_w = {div_quo_q[47:0], dv_ge_w};
	wire [47:0] inc_diff_w = (ext_inc_q >= int_inc_q) ? ext_inc_q - int_inc_q :
		int_inc_q - ext_inc_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ttl_s_q <= 3'd0;
			cmp_s_q <= 3'd0;
			tb_s_q <= 3'd0;
			per_cnt_q <= 40'd0;
			ext_seen_q <= 1'b0;
			ext_lock_q <= 1'b0;
			div_cnt_q <= 6'd0;
			div_per_q <= 40'd0;
			div_rem_q <= 41'd0;
			div_num_q <= 49'd0;
			div_quo_q <= 49'd0;
			ext_inc_q <= 48'd0;
		end else begin
			ttl_s_q <= {ttl_s_q[1:0], ref_ttl};
			cmp_s_q <= {cmp_s_q[1:0], ref_cmp};
			tb_s_q <= {tb_s_q[1:0], tb_ext};
			per_cnt_q <= ext_edge_w ? 40'd1 : per_top_w ? per_cnt_q : per_cnt_q + 40'd1;
			ext_seen_q <= (ext_seen_q | ext_edge_w) & ~per_top_w;
			ext_lock_q <= ext_lock_d;
			if (ext_edge_w && per_good_w) begin
				div_per_q <= per_cnt_q;
				div_cnt_q <= DIV_STEPS;
				div_rem_q <= 41'd0;
				div_num_q <= DIV_NUM;
				div_quo_q <= 49'd0;
			end else if (div_cnt_q != 6'd0) begin
				div_rem_q <= dv_ge_w ? dv_trial_w - {1'b0, div_per_q} : dv_trial_w;
				div_num_q <= {div_num_q[47:0], 1'b0};
				div_quo_q <= dv_quo_w;
				div_cnt_q <= div_cnt_q - 6'd1;
				if (div_cnt_q == 6'd1) begin
					ext_inc_q <= dv_quo_w[47:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// oscillators, lock indicators, timebase detect
	// ----------------------------------------------------------------
	logic [15:0] tb_win_q, tb_cnt_q;
	localparam int TB_EXP = TB_WIN / (CLK_HZ / TB_HZ);
	localparam logic [15:0] TB_LO = 16'(TB_EXP * (100 - TB_TOL_PCT) / 100);
	localparam logic [15:0] TB_HI = 16'(TB_EXP * (100 + TB_TOL_PCT) / 100);
	wire tb_end_w = tb_win_q == 16'(TB_WIN - 1);
	wire [15:0] int_ph_w = int_acc_q[47:32];
	wire [15:0] ext_ph_w = ext_acc_q[47:32];
	wire [15:0] det_base_w =
		(src_w == LRG_SRC_EXT) ? harm_mul(n_ext_q, ext_ph_w) :
		(src_w == LRG_SRC_DUAL) ?
			harm_mul(n_int_q, int_ph_w) - harm_mul(n_ext_q, ext_ph_w) :
		harm_mul(n_int_q, int_ph_w);
	wire [15:0] det_i_w = det_base_w + ph_word(phase_q);
	wire unlock_d = (src_w == LRG_SRC_INT) ? 1'b0 :
		(src_w == LRG_SRC_CHOP) ? ~chop_lock_q : ~ext_lock_q;
	wire ext_sine_w = (src_w == LRG_SRC_EXT) || (src_w == LRG_SRC_CHOP);

	always_ff @(posedge clk) begin
		if (rst) begin
			int_inc_q <= 48'd0;
			int_acc_q <= 48'd0;
			ext_acc_q <= 48'd0;
			chop_lock_q <= 1'b0;
			unlock_q <= 1'b0;
			tb_win_q <= 16'd0;
			tb_cnt_q <= 16'd0;
			external_timebase_locked_flag_q <= 1'b0;
			det_ref_q <= '0;
			sine_q <= '0;
		end else begin
			int_inc_q <= nco_inc(freq_q);
			int_acc_q <= int_acc_q + int_inc_q;
			ext_acc_q <= ext_edge_w ? 48'd0 : ext_acc_q + ext_inc_q;
			chop_lock_q <= ext_lock_q && inc_diff_w <= (int_inc_q >> CHOP_TOL_SHIFT);
			unlock_q <= unlock_d;
			tb_win_q <= tb_end_w ? 16'd0 : tb_win_q + 16'd1;
			tb_cnt_q <= tb_end_w ? 16'd0 : tb_cnt_q + 16'(tb_s_q[1] & ~tb_s_q[2]);
			if (tb_end_w) begin
				external_timebase_locked_flag_q <= tb_cnt_q >= TB_LO && tb_cnt_q <= TB_HI;
			end
			det_ref_q.phase_i <= det_i_w;
			det_ref_q.phase_q <= det_i_w + 16'h4000;
			sine_q.phase <= ext_sine_w ? ext_ph_w : int_ph_w;
			sine_q.ampl <= ampl_q;
			sine_q.dc_pos <= dc_q;
			sine_q.dc_neg <= ctrl_q[CTRL_DC_COMMON] ? dc_q : -dc_q;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_cmd(int b);
		wr_w && paddr == LRG_CMD && pwdata[b];
	endsequence
	property p_pos_edge;
		trig_w == LRG_TRIG_POS && ttl_s_q[1] && !ttl_s_q[2] |=> ext_acc_q == 48'd0;
	endproperty
	a_pos_edge: assert property (p_pos_edge) else $error("pos edge did not restart phase");
	property p_sine_edge;
		trig_w == LRG_TRIG_SINE && $rose(cmp_s_q[1]) |-> ext_edge_w;
	endproperty
	a_sine_edge: assert property (p_sine_edge) else $error("zero crossing missed");
	property p_unlock_ext;
		(src_w == LRG_SRC_EXT || src_w == LRG_SRC_DUAL) && !ext_lock_q |=> unlock_q;
	endproperty
	a_unlock_ext: assert property (p_unlock_ext) else $error("unlock not shown");
	property p_unlock_chop;
		src_w == LRG_SRC_CHOP ##1 src_w == LRG_SRC_CHOP |-> unlock_q == !$past(chop_lock_q);
	endproperty
	a_unlock_chop: assert property (p_unlock_chop) else $error("chop unlock wrong");
	property p_phase_span;
		21'(phase_q) <= PH_MAX && 21'(phase_q) >= -PH_MAX;
	endproperty
	a_phase_span: assert property (p_phase_span) else $error("phase out of span");
	property p_plus90;
		s_cmd(CMD_PH_PLUS) ##0 !pwdata[CMD_PH_ZERO] && !pwdata[CMD_PH_AUTO]
			|=> phase_q == ph_wrap(21'($past(phase_q)) + PH_QUARTER);
	endproperty
	a_plus90: assert property (p_plus90) else $error("plus 90 wrong");
	property p_auto;
		s_cmd(CMD_PH_AUTO) ##0 !pwdata[CMD_PH_ZERO]
			|=> phase_q == ph_wrap(21'($past(phase_q)) - 21'($past(theta_meas)));
	endproperty
	a_auto: assert property (p_auto) else $error("auto phase wrong");
	property p_ext_freq;
		src_w == LRG_SRC_EXT |=> $stable(freq_q);
	endproperty
	a_ext_freq: assert property (p_ext_freq) else $error("frequency moved in external");
	property p_harm_reset;
		s_cmd(CMD_HARM_RESET) |=> n_int_q == HARM_MIN && n_ext_q == HARM_MIN;
	endproperty
	a_harm_reset: assert property (p_harm_reset) else $error("harmonic not reset");
	property p_harm_range;
		n_int_q >= HARM_MIN && n_int_q <= HARM_MAX && n_ext_q >= HARM_MIN && n_ext_q <= HARM_MAX;
	endproperty
	a_harm_range: assert property (p_harm_range) else $error("harmonic out of range");
	property p_fmax;
		43'(freq_q) * 43'(n_int_q) <= 43'(FREQ_MAX) && freq_q >= FREQ_MIN;
	endproperty
	a_fmax: assert property (p_fmax) else $error("frequency above ceiling");
	property p_dc_mode;
		!ctrl_q[CTRL_DC_COMMON] ##1 !ctrl_q[CTRL_DC_COMMON] |-> sine_q.dc_neg == -sine_q.dc_pos;
	endproperty
	a_dc_mode: assert property (p_dc_mode) else $error("difference dc wrong");
endmodule

// ==== testbench/lrg_partner.sv ====
module lrg_partner (
	input wire logic ref_on,
	input wire logic tb_on,
	output logic ref_ttl,
	output logic ref_cmp,
	output logic tb_ext
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// 250 kHz reference, not aligned to the bench clock
	// ----------------------------------------------------------------
	initial begin
		ref_ttl = 1'b0;
		#7;
		forever begin
			#2000;
			ref_ttl = ref_on ? ~ref_ttl : 1'b0;
		end
	end

	// comparator of a sine trails the square by a quarter turn; low before the first swing
	initial begin
		ref_cmp = 1'b0;
		forever begin
			@(ref_ttl);
			ref_cmp <= #1000 ref_ttl;
		end
	end

	// ----------------------------------------------------------------
	// 10 MHz timebase
	// ----------------------------------------------------------------
	initial begin
		tb_ext = 1'b0;
		#3;
		forever begin
			#50;
			tb_ext = tb_on ? ~tb_ext : 1'b0;
		end
	end
endmodule

// ==== testbench/lockin_reference_generator_tb_top.sv ====
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end

module lockin_reference_generator_tb_top
	import lrg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst, psel, penable, pwrite, pready_q, pslverr_q, unlock_q, tb_flag;
	logic ref_ttl, ref_cmp, tb_ext, ref_on, tb_on, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_q, rd, seed;
	logic signed [18:0] theta_meas;
	lrg_det_t det_ref_q;
	lrg_sine_t sine_q;
	int failures, num_checks, p, th;
	localparam logic [31:0] PM = 32'h1f_ffff;

	lrg_ref_gen #(.REF_TIMEOUT_CYC(40'd2000), .TB_WIN(500)) lrg_ref_gen_inst (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .ref_ttl(ref_ttl), .ref_cmp(ref_cmp), .tb_ext(tb_ext),
		.theta_meas(theta_meas), .det_ref_q(det_ref_q), .sine_q(sine_q),
		.unlock_q(unlock_q), .external_timebase_locked_flag_q(tb_flag));

	lrg_partner lrg_partner_inst (.ref_on(ref_on), .tb_on(tb_on), .ref_ttl(ref_ttl),
		.ref_cmp(ref_cmp), .tb_ext(tb_ext));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] wrap(input int v);
		if (v > 180000) v -= 360000;
		else if (v < -180000) v += 360000;
		return 32'(v);
	endfunction

	// request stands until pready_q is seen high at a rising edge; answer taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready_q !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40) failures++;
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic cmd(input int b);
		apb(1'b1, LRG_CMD, 32'h1 << b);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = '1);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e & m, rd & m)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, stimulus
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, ref_on, tb_on, theta_meas} = '0;
		seed = 32'hb9bab41c;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rchk("freq", LRG_FREQ_LO, FREQ_RST[31:0]);
		rchk("harm", LRG_HARM, 32'h0101, 32'h7f7f);
		apb(1'b0, 8'h28, 32'h0);
		`CHK("slverr", 1'b1, err)
		for (int i = 0; i < 6; i++) begin
			p = $signed(xs()) % 150000;
			wr(LRG_PHASE, 32'(p));
			cmd(i % 2 ? CMD_PH_MINUS : CMD_PH_PLUS);
			rchk("step", LRG_PHASE, wrap(p + (i % 2 ? -90000 : 90000)), PM);
			th = $signed(xs()) % 100000;
			theta_meas <= 19'(th);
			cmd(CMD_PH_AUTO);
			rchk("auto", LRG_PHASE, wrap(p + (i % 2 ? -90000 : 90000) - th), PM);
		end
		settle(1);
		`CHK("quad", 16'h4000, 16'(det_ref_q.phase_q - det_ref_q.phase_i))
		cmd(CMD_PH_ZERO);
		rchk("zero", LRG_PHASE, 32'h0, PM);
		wr(LRG_PHASE, 32'(200000));
		rchk("clamp", LRG_PHASE, 32'(180000), PM);
		settle(1);
		`CHK("shift", 16'h8000, 16'(det_ref_q.phase_i - sine_q.phase))
		repeat (100) cmd(CMD_HARM_UP);
		rchk("h99", LRG_HARM, 32'h0163, 32'h7f7f);
		cmd(CMD_HARM_RESET);
		cmd(CMD_HARM_DOWN);
		rchk("h1", LRG_HARM, 32'h0101, 32'h7f7f);
		wr(LRG_FREQ_LO, 32'd5);
		wr(LRG_FREQ_HI, 32'd0);
		rchk("fmin", LRG_FREQ_LO, FREQ_RST[31:0]);
		wr(LRG_FREQ_LO, 32'd2_500_000_000);
		wr(LRG_FREQ_HI, 32'd0);
		rchk("f250k", LRG_FREQ_LO, 32'd2_500_000_000);
		cmd(CMD_HARM_UP);
		cmd(CMD_HARM_UP);
		rchk("hcap", LRG_HARM, 32'h0102, 32'h7f7f);
		wr(LRG_FREQ_LO, 32'd705_032_704);
		wr(LRG_FREQ_HI, 32'd1);
		rchk("fcap", LRG_FREQ_LO, 32'd2_500_000_000);
		cmd(CMD_HARM_RESET);
		wr(LRG_CTRL, 32'h1);
		wr(LRG_FREQ_LO, 32'd1234);
		wr(LRG_FREQ_HI, 32'd0);
		rchk("fext", LRG_FREQ_LO, 32'd2_500_000_000);
		cmd(CMD_HARM_UP);
		rchk("hext", LRG_HARM, 32'h0201, 32'h7f7f);
		cmd(CMD_HARM_RESET);
		p = int'(xs() % 32'd2_000_000_001);
		wr(LRG_AMPL, 32'(p));
		settle(2);
		`CHK("ampl", 31'(p), sine_q.ampl)
		wr(LRG_AMPL, 32'h7fff_ffff);
		rchk("amax", LRG_AMPL, 32'(AMPL_MAX));
		cmd(CMD_AMPL_ZERO);
		settle(2);
		`CHK("azero", 31'h0, sine_q.ampl)
		p = $signed(xs()) % 50001;
		wr(LRG_DCLVL, 32'(p));
		settle(2);
		`CHK("dcneg", 17'(-p), sine_q.dc_neg)
		wr(LRG_CTRL, 32'h11);
		settle(2);
		`CHK("dccom", 17'(p), sine_q.dc_neg)
		wr(LRG_DCLVL, 32'(60000));
		rchk("dcmax", LRG_DCLVL, 32'(50000), 32'h1_ffff);
		cmd(CMD_DC_ZERO);
		settle(2);
		`CHK("dczero", 17'h0, sine_q.dc_pos)
		ref_on <= 1'b1;
		for (int t = 0; t < 3; t++) begin
			wr(LRG_CTRL, 32'(t * 4 + 1));
			settle(1500);
			`CHK("lock", 1'b0, unlock_q)
		end
		wr(LRG_CTRL, 32'hd);
		settle(3000);
		`CHK("lost", 1'b1, unlock_q)
		wr(LRG_CTRL, 32'h3);
		settle(2000);
		`CHK("chop", 1'b0, unlock_q)
		rchk("stat", LRG_STATUS, 32'hc, 32'hd);
		wr(LRG_FREQ_LO, FREQ_RST[31:0]);
		wr(LRG_FREQ_HI, 32'd0);
		settle(2000);
		`CHK("chopoff", 1'b1, unlock_q)
		wr(LRG_CTRL, 32'h22);
		cmd(CMD_HARM_UP);
		rchk("hdual", LRG_HARM, 32'h0201, 32'h7f7f);
		settle(2);
		`CHK("dual", 1'b0, unlock_q)
		tb_on <= 1'b1;
		settle(2000);
		`CHK("tbon", 1'b1, tb_flag)
		tb_on <= 1'b0;
		settle(2000);
		`CHK("tboff", 1'b0, tb_flag)
		results();
	end
endmodule
